// ---- design/cxd_consts.svh ----
// Purpose: Constants for the extended command decoder
// Assumes: One byte per register, index = APB byte address / 4
// Notes: Definitions only
`ifndef CXD_CONSTS_SVH
`define CXD_CONSTS_SVH
// Register indices of the configuration bytes
`define CXD_A_ICE 6'h00
`define CXD_A_ICP 6'h01
`define CXD_A_DIR 6'h02
`define CXD_A_OPT 6'h03
`define CXD_A_CONV1 6'h04
`define CXD_A_CONV0 6'h05
`define CXD_A_OPT2 6'h06
`define CXD_A_SCHED 6'h07
`define CXD_A_BT1 6'h08
`define CXD_A_BT2 6'h09
`define CXD_A_BT3 6'h0A
`define CXD_A_PR1 6'h0B
`define CXD_A_PR2 6'h0C
`define CXD_A_T1 6'h0D
`define CXD_A_T2 6'h0E
`define CXD_A_D1 6'h0F
`define CXD_A_D2 6'h10
`define CXD_A_MASK 6'h11
`define CXD_A_F0 6'h15
`define CXD_A_F1 6'h19
`define CXD_A_TX0 6'h1D
`define CXD_A_TX1 6'h21
`define CXD_A_TX2 6'h25
`define CXD_CFG_TOP 6'h28
// Read-only status indices
`define CXD_A_FLAGS 6'h29
`define CXD_A_PINS 6'h2A
`define CXD_A_ERROR_FLAG_REG 6'h2B
`define CXD_A_TEC 6'h2C
`define CXD_A_REC 6'h2D
// User memory occupies indices 0x30..0x3F
`define CXD_MEM_SEG 2'h3
// Field positions
`define CXD_TXONE_BIT 5
`define CXD_STEN_BIT 7
`define CXD_STMS_BIT 6
`define CXD_ID_B3 3
// Reset values
`define CXD_CFG_RST 8'h00
`define CXD_SCHED_RST 8'h3F
// Function codes, requests
`define CXD_FC_ANA 3'h0
`define CXD_FC_CTRL 3'h1
`define CXD_FC_CFG 3'h2
`define CXD_FC_ERR 3'h3
`define CXD_FC_PWM 3'h4
`define CXD_FC_MEM0 3'h5
`define CXD_FC_MEM1 3'h6
`define CXD_FC_REG 3'h7
// Function codes, input messages
`define CXD_FC_WREG 3'h0
`define CXD_FC_TX0 3'h1
`define CXD_FC_TX1 3'h2
`define CXD_FC_TX2 3'h3
`define CXD_FC_WIO 3'h4
`define CXD_FC_MASK 3'h5
`define CXD_FC_F0 3'h6
`define CXD_FC_F1 3'h7
// Byte counts
`define CXD_N_ANA 4'h8
`define CXD_N_CTRL 4'h7
`define CXD_N_CFG 4'h5
`define CXD_N_ERR 4'h3
`define CXD_N_PWM 4'h6
`define CXD_N_REG 4'h1
`define CXD_N_EDGE 4'h2
`define CXD_N_NONE 4'h0
`define CXD_N_WREG 4'h3
`define CXD_N_WID 4'h4
`define CXD_N_WIO 4'h5
`endif

// ---- design/cxd_pkg.sv ----
// Purpose: Types shared by the command decoder files
// Assumes: Extended frames only
// Notes: Data byte 0 sits in bits 7:0
package cxd_pkg;
  // One CAN frame as seen by the controller
  typedef struct packed {
    logic [28:0] id;
    logic rtr;
    logic ide;
    logic [3:0] dlc;
    logic [7:0][7:0] data;
  } cxd_frame_t;
  // Live device state sampled for answers
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] pins;
    logic [7:0] error_flag_reg;
    logic [7:0] tx_error_count;
    logic [7:0] rx_error_count;
  } cxd_status_t;
  // Converter results
  typedef struct packed {
    logic [7:0] a23l;
    logic [7:0] a3h;
    logic [7:0] a2h;
    logic [7:0] a01l;
    logic [7:0] a1h;
    logic [7:0] a0h;
  } cxd_analog_t;
  // Answer sequencer states
  typedef enum logic [1:0] {st_idle, st_fetch, st_build} cxd_state_t;
endpackage

// ---- design/cxd_mem.sv ----
// Purpose: User memory, byte lanes by bit mask
// Assumes: One write and one read port
// Notes: Read data is registered
`timescale 1ns/10ps
`default_nettype none
module cxd_mem #(
  parameter int WORDS = 2,
  parameter int W = 64
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, low
  input wire logic we, // Write strobe
  input wire logic [$clog2(WORDS)-1:0] wa, // Write word
  input wire logic [W-1:0] wd, // Write data
  input wire logic [W-1:0] wm, // Bit write mask
  input wire logic [$clog2(WORDS)-1:0] ra, // Read word
  output logic [W-1:0] rd // Registered read data
);
  logic [W-1:0] mem [WORDS]; // Storage

  // Masked write and registered read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < WORDS; i++) begin
        mem[i] <= '0;
      end
      rd <= '0;
    end else begin
      if (we) begin
        mem[wa] <= (mem[wa] & ~wm) | (wd & wm);
      end
      rd <= mem[ra];
    end
  end
endmodule
`default_nettype wire

// ---- design/cxd_txarb.sv ----
// Purpose: Fixed-priority transmit queue, highest index first
// Assumes: Loads are one-cycle pulses
// Notes: A load in the send cycle keeps the entry pending
`timescale 1ns/10ps
`default_nettype none
module cxd_txarb #(
  parameter int N = 4
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, low
  input wire logic [N-1:0] load, // Queue request per entry
  input wire cxd_pkg::cxd_frame_t [N-1:0] frames, // Frame per entry
  input wire logic tx_ready, // Controller takes frame
  output logic tx_valid, // Frame offered
  output cxd_pkg::cxd_frame_t tx_frame, // Offered frame
  output logic [N-1:0] pend // Entries waiting
);
  import cxd_pkg::*;
  localparam int IW = $clog2(N);
  cxd_frame_t [N-1:0] held; // Latched frames
  logic [IW-1:0] cur; // Entry being sent
  logic [IW-1:0] top; // Highest pending entry
  logic done; // Frame handed over

  assign done = tx_valid && tx_ready;

  // Highest index wins
  always_comb begin
    top = '0;
    for (int i = 0; i < N; i++) begin
      if (pend[i]) begin
        top = IW'(i);
      end
    end
  end

  // Per entry pending flag; set beats clear
  for (genvar g = 0; g < N; g++) begin : g_ent
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pend[g] <= 1'b0;
        held[g] <= '0;
      end else if (load[g]) begin
        pend[g] <= 1'b1;
        held[g] <= frames[g];
      end else if (done && cur == IW'(g)) begin
        pend[g] <= 1'b0;
      end
    end
  end

  // Offer one frame at a time, held until taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid <= 1'b0;
      cur <= '0;
      tx_frame <= '0;
    end else if (done) begin
      tx_valid <= 1'b0;
    end else if (!tx_valid && |pend) begin
      tx_valid <= 1'b1;
      cur <= top;
      tx_frame <= held[top];
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_prio;
    (!tx_valid && |pend) |=> (tx_valid && cur == $past(top));
  endproperty
  a_prio: assert property (p_prio) else $error("wrong entry chosen");
  property p_hold;
    (tx_valid && !tx_ready) |=> (tx_valid && $stable(tx_frame));
  endproperty
  a_hold: assert property (p_hold) else $error("frame dropped");
endmodule
`default_nettype wire

// ---- design/cxd_decoder.sv ----
// Purpose: Decode extended command frames, answer requests, queue auto frames
// Assumes: Frames from a CAN controller already passed acceptance
// Notes: Registers over APB, one byte per aligned word
// Operation
// - Low three ident bits select request kind
// - Code 001 returns seven control bytes
// - Code 010 returns direction, pins, timing
// - Code 011 returns error flags and counters
// - Code 100 returns six PWM bytes
// - Codes 101, 110 return user memory halves
// - Answer: data frame, extended, echoed code
// - Data request: length zero, bit3 set
// - Remote request: length equals answer count
// - Code 000 input writes masked register
// - Codes 001-011 load transmit slot idents
// - Code 100 loads five I/O config bytes
// - Code 101 loads acceptance mask
// - Codes 110, 111 load filters 0, 1
// - Four automatic frame kinds start internally
// - Slot 2 highest, all pending sent
// - Input edge sends slot 2, two bytes, eight with a same-cycle analog crossing
// - Analog crossing sends slot 2, eight bytes
// - Enabled error event sends slot 1
// - Scheduled frame slot 0, none or eight
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "cxd_consts.svh"
module cxd_decoder (
  input wire logic pclk, // Clock, 25 MHz
  input wire logic presetn, // Async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped
  input wire logic rx_valid, // Received frame offered
  output logic rx_ready, // Frame taken
  input wire cxd_pkg::cxd_frame_t rx_frame, // Received frame
  output logic tx_valid, // Frame to send
  input wire logic tx_ready, // Controller takes it
  output cxd_pkg::cxd_frame_t tx_frame, // Frame to send
  input wire cxd_pkg::cxd_status_t status, // Live status bytes
  input wire cxd_pkg::cxd_analog_t analog, // Converter results
  input wire logic edge_event, // Input edge pulse
  input wire logic analog_event, // Threshold crossing pulse
  input wire logic error_event, // Error state pulse
  input wire logic sched_tick // Schedule interval pulse
);
  import cxd_pkg::*;

  logic [7:0] cfg [0:`CXD_CFG_TOP]; // Configuration bytes
  cxd_state_t state; // Answer sequencer
  logic [28:0] req_id; // Latched request ident
  logic req_rtr; // Latched remote flag
  wire [2:0] fc = rx_frame.id[2:0]; // Function code
  logic [3:0] in_cnt; // Input message length
  logic [5:0] blk_base; // Block write base
  logic is_req, is_cmd, take, cmd, blk_we, reg_we, cmd_mem;
  wire [7:0] wr_addr = rx_frame.data[0]; // Write target
  wire [7:0] wr_mask = rx_frame.data[1]; // Write mask
  wire [7:0] wr_val = rx_frame.data[2]; // Write value
  logic [5:0] idx; // APB register index
  logic is_mem, mapped, apb_ok, apb_we;
  logic mem_we, mem_wa, mem_ra;
  logic [63:0] mem_wd, mem_wm, mem_rd;
  logic [7:0] reg_val; // Single register answer
  logic [63:0] ana_bytes; // Analog answer payload
  cxd_frame_t ans; // Answer frame
  cxd_frame_t [3:0] slot_f; // Queue entries
  logic [3:0] slot_ld, pend;

  // Answer byte count per request code
  function automatic logic [3:0] cnt_of(input logic [2:0] f);
    unique case (f)
      `CXD_FC_ANA, `CXD_FC_MEM0, `CXD_FC_MEM1: cnt_of = `CXD_N_ANA;
      `CXD_FC_CTRL: cnt_of = `CXD_N_CTRL;
      `CXD_FC_CFG: cnt_of = `CXD_N_CFG;
      `CXD_FC_ERR: cnt_of = `CXD_N_ERR;
      `CXD_FC_PWM: cnt_of = `CXD_N_PWM;
      `CXD_FC_REG: cnt_of = `CXD_N_REG;
    endcase
  endfunction

  // Register byte by index, status included
  function automatic logic [7:0] reg_byte(input logic [5:0] a);
    unique case (a)
      `CXD_A_FLAGS: reg_byte = status.flags;
      `CXD_A_PINS: reg_byte = status.pins;
      `CXD_A_ERROR_FLAG_REG: reg_byte = status.error_flag_reg;
      `CXD_A_TEC: reg_byte = status.tx_error_count;
      `CXD_A_REC: reg_byte = status.rx_error_count;
      default: reg_byte = (a <= `CXD_CFG_TOP) ? cfg[a] : 8'h00;
    endcase
  endfunction

  // Transmit ident from four slot bytes
  function automatic logic [28:0] slot_id(input logic [5:0] b);
    slot_id = {cfg[b], cfg[b + 6'h01][7:5], cfg[b + 6'h01][1:0],
               cfg[b + 6'h02], cfg[b + 6'h03]};
  endfunction

  // Input message length and target block
  always_comb begin
    in_cnt = `CXD_N_WID;
    blk_base = `CXD_A_TX0;
    unique case (fc)
      `CXD_FC_WREG: in_cnt = `CXD_N_WREG;
      `CXD_FC_TX0: blk_base = `CXD_A_TX0;
      `CXD_FC_TX1: blk_base = `CXD_A_TX1;
      `CXD_FC_TX2: blk_base = `CXD_A_TX2;
      `CXD_FC_WIO: begin
        in_cnt = `CXD_N_WIO;
        blk_base = `CXD_A_ICE;
      end
      `CXD_FC_MASK: blk_base = `CXD_A_MASK;
      `CXD_FC_F0: blk_base = `CXD_A_F0;
      `CXD_FC_F1: blk_base = `CXD_A_F1;
    endcase
  end

  // Frame classification; anything else is dropped
  assign is_req = rx_frame.ide && (rx_frame.rtr ? rx_frame.dlc == cnt_of(fc)
                  : (rx_frame.dlc == `CXD_N_NONE && rx_frame.id[`CXD_ID_B3]));
  assign is_cmd = rx_frame.ide && !rx_frame.rtr && rx_frame.dlc == in_cnt;
  assign rx_ready = (state == st_idle) && !pend[3];
  assign take = rx_valid && rx_ready;
  assign cmd = take && is_cmd;
  assign blk_we = cmd && fc != `CXD_FC_WREG;
  assign reg_we = cmd && fc == `CXD_FC_WREG && wr_addr <= {2'h0, `CXD_CFG_TOP};
  assign cmd_mem = cmd && fc == `CXD_FC_WREG && wr_addr[7:4] == {2'h0, `CXD_MEM_SEG};

  // Configuration bytes: frame writes first, then APB
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i <= `CXD_CFG_TOP; i++) begin
        cfg[i] <= `CXD_CFG_RST;
      end
      cfg[`CXD_A_SCHED] <= `CXD_SCHED_RST;
    end else begin
      for (int i = 0; i <= `CXD_CFG_TOP; i++) begin
        if (blk_we && (6'(i) - blk_base) < 6'(in_cnt)) begin
          cfg[i] <= rx_frame.data[3'(6'(i) - blk_base)];
        end else if (reg_we && wr_addr == 8'(i)) begin
          cfg[i] <= (cfg[i] & ~wr_mask) | (wr_val & wr_mask);
        end else if (apb_we && idx == 6'(i)) begin
          cfg[i] <= pwdata[7:0];
        end
      end
    end
  end

  // User memory port; frame write wins over APB
  assign mem_we = cmd_mem || (apb_we && is_mem);
  assign mem_wa = cmd_mem ? wr_addr[3] : idx[3];
  assign mem_wd = cmd_mem ? {8{wr_val}} : {8{pwdata[7:0]}};
  assign mem_wm = (cmd_mem ? {56'h0, wr_mask} : 64'h00000000000000FF)
                  << {(cmd_mem ? wr_addr[2:0] : idx[2:0]), 3'h0};
  assign mem_ra = (state == st_fetch) ? ((req_id[2:0] == `CXD_FC_REG) ? req_id[11]
                  : req_id[2:0] == `CXD_FC_MEM1) : idx[3];

  cxd_mem #(.WORDS(2), .W(64)) u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .we(mem_we),
    .wa(mem_wa),
    .wd(mem_wd),
    .wm(mem_wm),
    .ra(mem_ra),
    .rd(mem_rd)
  );

  // Request sequencer: take, fetch memory, build answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_idle;
    end else begin
      unique case (state)
        st_idle: if (take && is_req) begin
          state <= st_fetch;
        end
        st_fetch: state <= st_build;
        st_build: state <= st_idle;
      endcase
    end
  end

  // Latch the request ident and form
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_id <= '0;
      req_rtr <= 1'b0;
    end else if (take && is_req) begin
      req_id <= rx_frame.id;
      req_rtr <= rx_frame.rtr;
    end
  end

  assign ana_bytes = {analog.a23l, analog.a3h, analog.a2h, analog.a01l,
                      analog.a1h, analog.a0h, status.pins, status.flags};

  // Single register value; address rides in ident bits 15:8
  always_comb begin
    if (req_id[15:12] == {2'h0, `CXD_MEM_SEG}) begin
      reg_val = mem_rd[{req_id[10:8], 3'h0} +: 8];
    end else if (req_id[15:14] == 2'h0) begin
      reg_val = reg_byte(req_id[13:8]);
    end else begin
      reg_val = 8'h00;
    end
  end

  // Answer frame for the latched request
  always_comb begin
    ans = '0;
    ans.id = {req_id[28:4], req_id[3] & req_rtr, req_id[2:0]};
    ans.ide = 1'b1;
    ans.dlc = cnt_of(req_id[2:0]);
    unique case (req_id[2:0])
      `CXD_FC_ANA: ans.data = ana_bytes;
      `CXD_FC_CTRL: ans.data = {8'h00, cfg[`CXD_A_ICP], cfg[`CXD_A_ICE], cfg[`CXD_A_SCHED],
                                cfg[`CXD_A_OPT2], cfg[`CXD_A_OPT], cfg[`CXD_A_CONV1],
                                cfg[`CXD_A_CONV0]};
      `CXD_FC_CFG: ans.data = {24'h0, cfg[`CXD_A_BT3], cfg[`CXD_A_BT2], cfg[`CXD_A_BT1],
                               status.pins, cfg[`CXD_A_DIR]};
      `CXD_FC_ERR: ans.data = {40'h0, status.rx_error_count, status.tx_error_count, status.error_flag_reg};
      `CXD_FC_PWM: ans.data = {16'h0, cfg[`CXD_A_D2], cfg[`CXD_A_D1], cfg[`CXD_A_T2],
                               cfg[`CXD_A_T1], cfg[`CXD_A_PR2], cfg[`CXD_A_PR1]};
      `CXD_FC_MEM0, `CXD_FC_MEM1: ans.data = mem_rd;
      `CXD_FC_REG: ans.data = {56'h0, reg_val};
    endcase
  end

  // Queue entries: 3 answer, 2 edge/analog, 1 error, 0 schedule
  always_comb begin
    slot_f = '0;
    slot_f[3] = ans;
    slot_f[2].id = slot_id(`CXD_A_TX2);
    slot_f[2].ide = 1'b1;
    slot_f[2].dlc = analog_event ? `CXD_N_ANA : `CXD_N_EDGE;
    slot_f[2].data = analog_event ? ana_bytes : {48'h0, status.pins, status.flags};
    slot_f[1].id = slot_id(`CXD_A_TX1);
    slot_f[1].ide = 1'b1;
    slot_f[1].dlc = `CXD_N_ERR;
    slot_f[1].data = {40'h0, status.rx_error_count, status.tx_error_count, status.error_flag_reg};
    slot_f[0].id = slot_id(`CXD_A_TX0);
    slot_f[0].ide = 1'b1;
    if (cfg[`CXD_A_SCHED][`CXD_STMS_BIT]) begin
      slot_f[0].dlc = `CXD_N_ANA;
      slot_f[0].data = ana_bytes;
    end
  end

  // Event sources for the queue
  assign slot_ld = {state == st_build, edge_event || analog_event,
                    error_event && cfg[`CXD_A_OPT2][`CXD_TXONE_BIT],
                    sched_tick && cfg[`CXD_A_SCHED][`CXD_STEN_BIT]};

  cxd_txarb #(.N(4)) u_arb (
    .pclk(pclk),
    .presetn(presetn),
    .load(slot_ld),
    .frames(slot_f),
    .tx_ready(tx_ready),
    .tx_valid(tx_valid),
    .tx_frame(tx_frame),
    .pend(pend)
  );

  // APB decode; memory reads wait for their own read cycle
  assign idx = paddr[7:2];
  assign is_mem = idx[5:4] == `CXD_MEM_SEG;
  assign mapped = is_mem || idx <= `CXD_A_REC;
  assign pready = !cmd && (!is_mem || pwrite || apb_ok);
  assign pslverr = psel && penable && !mapped;
  assign apb_we = psel && penable && pwrite && pready && mapped;
  assign prdata = !mapped ? 32'h0 : {24'h0, is_mem ? mem_rd[{idx[2:0], 3'h0} +: 8]
                                                 : reg_byte(idx)};

  // Memory read data belongs to APB when last cycle was not a fetch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_ok <= 1'b0;
    end else begin
      apb_ok <= psel && (state != st_fetch);
    end
  end

  // Checks
  logic [5:0] chk_a; // Write target of the previous cycle
  logic [7:0] exp_byte; // Expected masked result
  assign exp_byte = (reg_byte(wr_addr[5:0]) & ~wr_mask) | (wr_val & wr_mask);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_a <= 6'h00;
    end else begin
      chk_a <= wr_addr[5:0];
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_req;
    take && is_req;
  endsequence
  sequence s_data_req;
    take && is_req && !rx_frame.rtr;
  endsequence
  property p_answer_form;
    s_req |-> ##2 (slot_ld[3] && ans.ide && !ans.rtr);
  endproperty
  a_answer_form: assert property (p_answer_form) else $error("answer form");
  property p_code_echo;
    s_req |-> ##2 (ans.id[2:0] == $past(fc, 2));
  endproperty
  a_code_echo: assert property (p_code_echo) else $error("code not echoed");
  property p_bit3;
    s_data_req |-> ##2 !ans.id[`CXD_ID_B3];
  endproperty
  a_bit3: assert property (p_bit3) else $error("bit3 not cleared");
  property p_ctrl_len;
    (s_req and (fc == `CXD_FC_CTRL)) |-> ##2 (ans.dlc == 4'h7);
  endproperty
  a_ctrl_len: assert property (p_ctrl_len) else $error("control length");
  property p_ignore;
    (take && !is_req && !is_cmd) |=> (state == st_idle) [*2];
  endproperty
  a_ignore: assert property (p_ignore) else $error("bad frame answered");
  property p_masked;
    reg_we |=> (reg_byte(chk_a) == $past(exp_byte));
  endproperty
  a_masked: assert property (p_masked) else $error("masked write");
  property p_edge;
    (edge_event && !analog_event) |=> (pend[2] || tx_valid);
  endproperty
  a_edge: assert property (p_edge) else $error("edge not queued");
  property p_err_gate;
    (error_event && !cfg[`CXD_A_OPT2][`CXD_TXONE_BIT] && !pend[1]) |=> !pend[1];
  endproperty
  a_err_gate: assert property (p_err_gate) else $error("error sent disabled");
  property p_sched;
    (sched_tick && cfg[`CXD_A_SCHED][`CXD_STEN_BIT]) |=> pend[0];
  endproperty
  a_sched: assert property (p_sched) else $error("schedule not queued");
endmodule
`default_nettype wire

// ---- bench/cxd_node.sv ----
// Purpose: Remote CAN node and controller stand-in for the decoder
// Assumes: One received frame offered at a time
// Notes: Sent frames are queued for the bench to pop
`timescale 1ns/10ps
`default_nettype none
module cxd_node (
  input wire logic pclk, // Clock
  input wire logic slow, // Take frames every other cycle
  input wire logic rx_ready, // Decoder took the frame
  input wire logic tx_valid, // Decoder offers a frame
  input wire cxd_pkg::cxd_frame_t tx_frame, // Frame from decoder
  output logic rx_valid, // Frame offered to decoder
  output logic tx_ready, // Frame taken from decoder
  output cxd_pkg::cxd_frame_t rx_frame // Frame to decoder
);
  import cxd_pkg::*;
  cxd_frame_t q[$]; // Frames seen leaving the decoder
  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
    tx_ready = 1'b0;
  end
  // Request idents kept apart from command idents by callers
  task automatic send(input cxd_frame_t f);
    rx_frame <= f;
    rx_valid <= 1'b1;
    @(posedge pclk);
    while (!rx_ready) @(posedge pclk);
    rx_valid <= 1'b0;
    rx_frame <= ~f; // Released lines do not keep the old value
    @(posedge pclk); // Let an edge pass so a following frame never reassigns in this step
  endtask
  // Take offered frames, stalling when slow
  always @(posedge pclk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (tx_valid && tx_ready) q.push_back(tx_frame);
  end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Purpose: Self-checking bench for the extended command decoder
// Assumes: Node model stands in for the CAN controller
// Notes: Registers hold index xor 5A before commands
`timescale 1ns/10ps
`default_nettype none
`include "cxd_consts.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module testbench;
  import cxd_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, rx_valid, rx_ready, tx_valid, tx_ready;
  logic [3:0] ev = '0; // Edge, analog, error, schedule pulses
  logic [28:0] id;
  cxd_frame_t rx_frame, tx_frame;
  cxd_status_t st = {8'hF1, 8'hE2, 8'hC3, 8'hB4, 8'hA5};
  cxd_analog_t an = 48'h665544332211;
  int fail_count = 0, check_count = 0;
  logic [3:0] cnt [8] = '{4'h8, 4'h7, 4'h5, 4'h3, 4'h6, 4'h8, 4'h8, 4'h1}; // Answer byte counts
  logic [5:0] base [8] = '{6'h00, 6'h1D, 6'h21, 6'h25, 6'h00, 6'h11, 6'h15, 6'h19};
  always #20 pclk = ~pclk;
  cxd_decoder uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_valid, .rx_ready, .rx_frame, .tx_valid, .tx_ready, .tx_frame,
    .status(st), .analog(an), .edge_event(ev[3]), .analog_event(ev[2]),
    .error_event(ev[1]), .sched_tick(ev[0]));
  cxd_node node (.pclk, .slow, .rx_ready, .tx_valid, .tx_frame, .rx_valid, .tx_ready,
    .rx_frame);
  // Initial register contents
  function automatic logic [7:0] rv(input int i);
    return 8'(i) ^ 8'h5A;
  endfunction
  // Command payload bytes
  function automatic logic [63:0] cmdd(input int c);
    for (int k = 0; k < 8; k++) cmdd[8*k +: 8] = 8'(c * 16 + k + 1);
  endfunction
  // Slot ident built from a loaded payload
  function automatic logic [28:0] sid(input int c);
    logic [63:0] b;
    b = cmdd(c);
    return {b[7:0], b[15:13], b[9:8], b[23:16], b[31:24]};
  endfunction
  function automatic cxd_frame_t mk(input logic [28:0] i, input logic r,
                                    input logic [3:0] n, input logic [63:0] d);
    return {i, r, 1'b1, n, d};
  endfunction
  // Expected answer bytes per request code
  function automatic logic [63:0] expd(input int c);
    case (c)
      0: expd = {an, st.pins, st.flags};
      1: expd = {8'h0, rv(1), rv(0), rv(7), rv(6), rv(3), rv(4), rv(5)};
      2: expd = {24'h0, rv(10), rv(9), rv(8), st.pins, rv(2)};
      3: expd = {40'h0, st.rx_error_count, st.tx_error_count, st.error_flag_reg};
      4: expd = {16'h0, rv(16), rv(15), rv(14), rv(13), rv(12), rv(11)};
      7: expd = {56'h0, rv(11)};
      default: for (int k = 0; k < 8; k++) expd[8*k +: 8] = rv(8 * c + 8 + k);
    endcase
  endfunction
  // One APB transfer; d is write data or expected read data
  task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] d, input logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    `CHK(pslverr, e)
    if (!w) `CHK(prdata, {24'h0, d})
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Wait for the next sent frame and compare the used bytes
  task automatic cf(input cxd_frame_t e);
    cxd_frame_t g;
    logic [63:0] m;
    int n;
    m = (64'h1 << (8 * e.dlc)) - 64'h1;
    n = 0;
    while (node.q.size() == 0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    `CHK(node.q.size() != 0, 1'b1)
    g = node.q.size() != 0 ? node.q.pop_front() : '0;
    `CHK({g.id, g.rtr, g.ide, g.dlc}, {e.id, e.rtr, e.ide, e.dlc})
    `CHK(g.data & m, e.data & m)
  endtask
  task automatic pulse(input logic [3:0] m);
    ev <= m;
    @(posedge pclk);
    ev <= 4'h0;
    repeat (20) @(posedge pclk);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    conclude();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `CXD_A_SCHED, `CXD_SCHED_RST, 0); // Reset value
    apb(0, `CXD_A_ICE, `CXD_CFG_RST, 0); // Reset value
    for (int i = 0; i < 64; i++) if (i < 'h29 || i >= 'h30) apb(1, 6'(i), rv(i), 0);
    apb(1, 6'h2E, 8'h77, 1); // Unmapped write refused
    apb(0, 6'h2E, 8'h00, 1); // Unmapped read refused
    apb(1, `CXD_A_TEC, 8'h00, 0);
    apb(0, `CXD_A_TEC, st.tx_error_count, 0); // Status stays live
    apb(0, 6'h3A, rv(58), 0); // User memory read through its own read cycle
    $display("register test done");
    for (int c = 0; c < 8; c++) begin
      for (int f = 0; f < 2; f++) begin
        id = {13'h1234, f ? 8'h3B : 8'h0B, 5'h0, 3'(c)};
        node.send(mk(id | (29'(f) << 3), f == 0, f ? 4'h0 : cnt[c], '0));
        cf(mk(id, 1'b0, cnt[c], (c == 7 && f) ? {56'h0, rv(59)} : expd(c))); // Answer
      end
    end
    $display("request test done");
    node.send(mk(29'h5, 1'b1, 4'h6, '0)); // Remote with wrong count
    node.send(mk(29'h1, 1'b0, 4'h0, '0)); // Data form without bit 3
    repeat (30) @(posedge pclk);
    `CHK(node.q.size(), 0) // No answer
    node.send(mk(29'h100, 1'b0, 4'h3, {40'h0, 8'h3C, 8'h0F, 8'h0B}));
    apb(0, 6'h0B, (rv(11) & 8'hF0) | 8'h0C, 0); // Masked bits only
    for (int c = 1; c < 8; c++) begin
      node.send(mk(29'h200 + 29'(c), 1'b0, c == 4 ? 4'h5 : 4'h4, cmdd(c)));
      for (int k = 0; k < (c == 4 ? 5 : 4); k++)
        apb(0, base[c] + 6'(k), 8'(cmdd(c) >> (8 * k)), 0);
    end
    $display("command test done");
    pulse(4'b0011); // Error and schedule frames still disabled
    `CHK(node.q.size(), 0) // Nothing sent
    apb(1, `CXD_A_OPT2, 8'h20, 0);
    apb(1, `CXD_A_SCHED, 8'hC0, 0);
    slow <= 1'b1;
    pulse(4'b1011);
    cf(mk(sid(3), 1'b0, 4'h2, {48'h0, st.pins, st.flags})); // Edge first
    cf(mk(sid(2), 1'b0, 4'h3, {40'h0, st.rx_error_count, st.tx_error_count, st.error_flag_reg})); // Error next
    cf(mk(sid(1), 1'b0, 4'h8, {an, st.pins, st.flags})); // Schedule last
    pulse(4'b0100);
    cf(mk(sid(3), 1'b0, 4'h8, {an, st.pins, st.flags})); // Analog crossing
    apb(1, `CXD_A_SCHED, 8'h80, 0);
    pulse(4'b0001);
    cf(mk(sid(1), 1'b0, 4'h0, '0)); // Empty scheduled frame
    $display("automatic frame test done");
    conclude();
  end
endmodule
`default_nettype wire
